/* File: pfrc_map.svh */
`ifndef PFRC_MAP_SVH
`define PFRC_MAP_SVH
// word and address geometry
`define PFRC_WORD_W        14
`define PFRC_ADDR_W        15
`define PFRC_ROW_LSB       5
`define PFRC_ROW_WORDS     32
`define PFRC_LATCH_COUNT   32
`define PFRC_WP_W          2
// fetch lands two instruction cycles after the read start
`define PFRC_FETCH_DELAY   2
// reset values
`define PFRC_DATA_RST      14'h0000
`define PFRC_ADDR_RST      15'h0000
`endif

/* File: pfrc_pkg.sv */
`default_nettype none
`include "pfrc_map.svh"
package pfrc_pkg;
	typedef enum logic [1:0] {
		PFRC_OP_NONE,
		PFRC_OP_ERASE,
		PFRC_OP_WRITE
	} pfrc_op_type;

	// one request from the core side register writes
	typedef struct packed {
		logic       wr_addr_high;
		logic       wr_addr_low;
		logic       wr_data_high;
		logic       wr_data_low;
		logic [7:0] wdata;
	} pfrc_reg_wr_type;

	// command to the flash array
	typedef struct packed {
		pfrc_op_type                op;
		logic [`PFRC_ADDR_W-1:0]    addr;
	} pfrc_cmd_type;
endpackage
`default_nettype wire

/* File: pfrc_protect.sv */
`default_nettype none
`include "pfrc_map.svh"
// decides whether an address lies in a write-protected segment
module pfrc_protect #(
	parameter int ADDR_W = `PFRC_ADDR_W
) (
	input  wire logic [ADDR_W-1:0]     addr_i,
	input  wire logic [`PFRC_WP_W-1:0] write_protect_field_i,
	output logic                       allowed_o
);
	logic [1:0] quarter;

	// protected segment shrinks as the field grows: 11 none, 10 first eighth, 01 first half, 00 all
	always_comb begin
		quarter = addr_i[ADDR_W-1 -: 2];
		case (write_protect_field_i)
			2'h3: allowed_o = 1'b1;
			2'h2: allowed_o = (addr_i[ADDR_W-1 -: 3] != 3'h0);
			2'h1: allowed_o = quarter[1];
			default: allowed_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* File: pfrc_top.sv */
// Notes on behaviour
// RQ1: program memory is rows of 14-bit words and an erase always clears a whole row.
// RQ2: a write or erase proceeds only when its address is outside the protected segment set by the two-bit field.
// RQ3: after an erase software may program the whole row or only some of its words.
// RQ4: 14-bit latches hidden from software are loaded through successive writes to the data high and low registers.
// RQ5: when latches are fewer than row words, each latch batch is programmed on its own until the row is done.
// RQ6: software loads the address pair, clears config select, sets program select, then sets the read bit.
// RQ7: the second instruction cycle after the read bit is set fetches the word and that instruction is not executed.
// RQ8: the fetched word appears in the data pair the cycle after the fetch, readable as two bytes.
// RQ9: the data pair keeps the fetched value until another read or a software write to it.
// RQ10: software places two no-operations after the read start.
// RQ11: reads complete whatever the code protection setting.
// RQ12: row and latch set are both 32 words aligned where the five lowest address bits are zero.
// RQ13: to change part of a programmed row software reads and saves the whole row before erasing.
// RQ14: a write or erase aimed at a protected segment is ignored and leaves the memory unchanged.
`default_nettype none
`include "pfrc_map.svh"
module pfrc_top #(
	parameter int WORD_W   = `PFRC_WORD_W,
	parameter int ADDR_W   = `PFRC_ADDR_W,
	parameter int ROW_LSB  = `PFRC_ROW_LSB,
	parameter int LATCHES  = `PFRC_LATCH_COUNT
) (
	input  wire logic                    clk_sys_i,
	input  wire logic                    srst_i,
	input  wire pfrc_pkg::pfrc_reg_wr_type reg_wr_i,
	input  wire logic                    read_start_i,
	input  wire logic                    config_space_select_i,
	input  wire logic                    program_space_select_i,
	input  wire logic                    erase_start_i,
	input  wire logic                    write_start_i,
	input  wire logic [`PFRC_WP_W-1:0]   write_protect_field_i,
	input  wire logic                    code_protect_i,
	input  wire logic [WORD_W-1:0]       flash_rdata_i,
	output logic [7:0]                   flash_addr_high_o,
	output logic [7:0]                   flash_addr_low_o,
	output logic [7:0]                   flash_data_high_o,
	output logic [7:0]                   flash_data_low_o,
	output logic                         busy_o,
	output logic                         instr_suppress_o,
	output logic                         rejected_o,
	output logic                         flash_rd_o,
	output logic [ADDR_W-1:0]            flash_addr_o,
	output logic                         flash_erase_o,
	output logic                         flash_prog_o,
	output logic [LATCHES-1:0]           flash_prog_mask_o,
	output logic [LATCHES*WORD_W-1:0]    flash_wdata_o
);
	import pfrc_pkg::*;

	localparam int LIDX_W = $clog2(LATCHES);

	typedef enum logic [1:0] {
		PFRC_IDLE,
		PFRC_WAIT,
		PFRC_FETCH
	} pfrc_rd_state_type;

	logic [ADDR_W-1:0]      addr_ff;
	logic [ADDR_W-1:0]      nxt_addr;
	logic [WORD_W-1:0]      data_ff;
	logic [WORD_W-1:0]      nxt_data;
	pfrc_rd_state_type      rd_state_ff;
	pfrc_rd_state_type      nxt_rd_state;
	logic [WORD_W-1:0]      latch_ff [LATCHES];
	logic [WORD_W-1:0]      nxt_latch [LATCHES];
	logic [LATCHES-1:0]     loaded_ff;
	logic [LATCHES-1:0]     nxt_loaded;
	pfrc_cmd_type           cmd_ff;
	pfrc_cmd_type           nxt_cmd;
	logic [LATCHES-1:0]     mask_ff;
	logic [LATCHES-1:0]     nxt_mask;
	logic                   rej_ff;
	logic                   nxt_rej;
	logic                   allowed;
	logic [LIDX_W-1:0]      lidx;
	logic                   read_go;
	logic                   rd_fire;

	// protection check on the current address
	pfrc_protect #(
		.ADDR_W(ADDR_W)
	) u_protect (
		.addr_i               (addr_ff),
		.write_protect_field_i(write_protect_field_i),
		.allowed_o            (allowed)
	);

	// RQ12 latch slot from the low address bits
	assign lidx    = addr_ff[LIDX_W-1:0];
	// RQ6 read only in program space with config select clear
	assign read_go = read_start_i && program_space_select_i && !config_space_select_i && (rd_state_ff == PFRC_IDLE);
	// RQ11 code protect is deliberately not consulted for reads
	assign rd_fire = (rd_state_ff == PFRC_FETCH);

	// address pair and read sequencer next state
	always_comb begin
		nxt_addr     = addr_ff;
		nxt_rd_state = rd_state_ff;
		if (reg_wr_i.wr_addr_high) begin
			nxt_addr[ADDR_W-1:8] = reg_wr_i.wdata[ADDR_W-9:0];
		end
		if (reg_wr_i.wr_addr_low) begin
			nxt_addr[7:0] = reg_wr_i.wdata;
		end
		// RQ7 second cycle after the start is the fetch slot
		case (rd_state_ff)
			PFRC_IDLE: begin
				if (read_go) begin
					nxt_rd_state = PFRC_WAIT;
				end
			end
			PFRC_WAIT:  nxt_rd_state = PFRC_FETCH;
			PFRC_FETCH: nxt_rd_state = PFRC_IDLE;
			default:    nxt_rd_state = PFRC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			addr_ff     <= `PFRC_ADDR_RST;
			rd_state_ff <= PFRC_IDLE;
		end else begin
			addr_ff     <= nxt_addr;
			rd_state_ff <= nxt_rd_state;
		end
	end

	// data pair: fetch wins over a software write in the same cycle
	always_comb begin
		nxt_data = data_ff;
		// RQ9 held until a user write or next read
		if (reg_wr_i.wr_data_high) begin
			nxt_data[WORD_W-1:8] = reg_wr_i.wdata[WORD_W-9:0];
		end
		if (reg_wr_i.wr_data_low) begin
			nxt_data[7:0] = reg_wr_i.wdata;
		end
		// RQ8 word lands in the pair right after the fetch
		if (rd_fire) begin
			nxt_data = flash_rdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			data_ff <= `PFRC_DATA_RST;
		end else begin
			data_ff <= nxt_data;
		end
	end

	// write latches and program/erase command
	always_comb begin
		for (int i = 0; i < LATCHES; i++) begin
			nxt_latch[i] = latch_ff[i];
		end
		nxt_loaded = loaded_ff;
		nxt_cmd    = '{op: PFRC_OP_NONE, addr: addr_ff};
		nxt_mask   = '0;
		nxt_rej    = 1'b0;
		// RQ4 low byte write completes the word into the hidden latch
		if (reg_wr_i.wr_data_low && !busy_o) begin
			nxt_latch[lidx]  = {data_ff[WORD_W-1:8], reg_wr_i.wdata};
			nxt_loaded[lidx] = 1'b1;
		end
		if ((erase_start_i || write_start_i) && !busy_o) begin
			if (allowed) begin
				// RQ1 erase addresses the whole aligned row
				if (erase_start_i) begin
					nxt_cmd.op   = PFRC_OP_ERASE;
					nxt_cmd.addr = {addr_ff[ADDR_W-1:ROW_LSB], {ROW_LSB{1'b0}}};
				end else begin
					// RQ3 RQ5 only loaded latches program, batch by batch
					nxt_cmd.op   = PFRC_OP_WRITE;
					nxt_cmd.addr = {addr_ff[ADDR_W-1:LIDX_W], {LIDX_W{1'b0}}};
					nxt_mask     = loaded_ff;
					nxt_loaded   = '0;
				end
			end else begin
				// RQ2 RQ14 protected target: drop the request, memory untouched
				nxt_rej    = 1'b1;
				nxt_loaded = '0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			for (int i = 0; i < LATCHES; i++) begin
				latch_ff[i] <= '0;
			end
			loaded_ff <= '0;
			cmd_ff    <= '{op: PFRC_OP_NONE, addr: '0};
			mask_ff   <= '0;
			rej_ff    <= 1'b0;
		end else begin
			latch_ff  <= nxt_latch;
			loaded_ff <= nxt_loaded;
			cmd_ff    <= nxt_cmd;
			mask_ff   <= nxt_mask;
			rej_ff    <= nxt_rej;
		end
	end

	// flatten latches onto the program data bus
	genvar g;
	generate
		for (g = 0; g < LATCHES; g++) begin : g_wdata
			assign flash_wdata_o[g*WORD_W +: WORD_W] = latch_ff[g];
		end
	endgenerate

	// outputs; code_protect_i is kept on the port for completeness only
	assign busy_o            = (rd_state_ff != PFRC_IDLE);
	// RQ7 the slot being fetched is the suppressed instruction
	assign instr_suppress_o  = rd_fire;
	assign flash_rd_o        = rd_fire;
	assign flash_addr_o      = (cmd_ff.op == PFRC_OP_NONE) ? addr_ff : cmd_ff.addr;
	assign flash_erase_o     = (cmd_ff.op == PFRC_OP_ERASE);
	assign flash_prog_o      = (cmd_ff.op == PFRC_OP_WRITE);
	assign flash_prog_mask_o = mask_ff;
	assign rejected_o        = rej_ff;
	assign flash_addr_high_o = {{(16-ADDR_W){1'b0}}, addr_ff[ADDR_W-1:8]};
	assign flash_addr_low_o  = addr_ff[7:0];
	assign flash_data_high_o = {{(16-WORD_W){1'b0}}, data_ff[WORD_W-1:8]};
	assign flash_data_low_o  = data_ff[7:0];
endmodule
`default_nettype wire

/* File: pfrc_flash_model.sv */
`default_nettype none
// array stand-in: each word is a fixed scramble of its address
module pfrc_flash_model (
	input  wire logic        rd_i,
	input  wire logic [14:0] addr_i,
	output logic      [13:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// off the fetch cycle the bus shows the inverse, so a late sample shows up
	assign rdata_o = rd_i ? addr_i[13:0] ^ 14'h2A5B : ~(addr_i[13:0] ^ 14'h2A5B);
endmodule
`default_nettype wire

/* File: pfrc_top_sva.sv */
`default_nettype none
// port-level checks on read timing, data pair and array commands
module pfrc_top_sva (
	input wire logic                      clk_sys_i,
	input wire logic                      srst_i,
	input wire pfrc_pkg::pfrc_reg_wr_type reg_wr_i,
	input wire logic                      read_start_i,
	input wire logic                      config_space_select_i,
	input wire logic                      program_space_select_i,
	input wire logic                      erase_start_i,
	input wire logic                      write_start_i,
	input wire logic [1:0]                write_protect_field_i,
	input wire logic [13:0]               flash_rdata_i,
	input wire logic [7:0]                flash_addr_high_o,
	input wire logic [7:0]                flash_addr_low_o,
	input wire logic [7:0]                flash_data_high_o,
	input wire logic [7:0]                flash_data_low_o,
	input wire logic                      busy_o,
	input wire logic                      instr_suppress_o,
	input wire logic                      rejected_o,
	input wire logic                      flash_rd_o,
	input wire logic [14:0]               flash_addr_o,
	input wire logic                      flash_erase_o,
	input wire logic                      flash_prog_o
);
	import pfrc_pkg::*;
	logic [14:0] a;
	logic        prot;
	logic        go;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// protection map as chosen for the segment field
	assign a    = {flash_addr_high_o[6:0], flash_addr_low_o};
	assign prot = write_protect_field_i == 2'h0 || (write_protect_field_i == 2'h1 && !a[14])
		|| (write_protect_field_i == 2'h2 && a[14:12] == 3'h0);
	assign go   = read_start_i && program_space_select_i && !config_space_select_i && !busy_o;
	fetch_slot_a: assert property (go |-> ##2 flash_rd_o && instr_suppress_o)
		else $error("fetch not in second slot");
	busy_span_a: assert property (go |=> busy_o ##1 busy_o ##1 !busy_o)
		else $error("busy span wrong");
	refused_read_a: assert property (read_start_i && !busy_o && !go |-> ##2 !flash_rd_o)
		else $error("read started with wrong selects");
	data_load_a: assert property (flash_rd_o |=> {flash_data_high_o, flash_data_low_o} == {2'h0, $past(flash_rdata_i)})
		else $error("fetched word not in data pair");
	data_hold_a: assert property (!flash_rd_o && !reg_wr_i.wr_data_high && !reg_wr_i.wr_data_low
		|=> $stable({flash_data_high_o, flash_data_low_o}))
		else $error("data pair changed");
	row_erase_a: assert property (erase_start_i && !busy_o && !prot |=> flash_erase_o
		&& flash_addr_o == {$past(a[14:5]), 5'h00})
		else $error("erase missing or unaligned");
	prog_go_a: assert property (write_start_i && !erase_start_i && !busy_o && !prot
		|=> flash_prog_o && flash_addr_o[4:0] == 5'h00)
		else $error("program missing or unaligned");
	protect_block_a: assert property ((erase_start_i || write_start_i) && !busy_o && prot
		|=> rejected_o && !flash_erase_o && !flash_prog_o)
		else $error("protected segment touched");
	no_stray_a: assert property (busy_o || !(erase_start_i || write_start_i)
		|=> !flash_erase_o && !flash_prog_o && !rejected_o)
		else $error("array command without request");
	cover property (go);
	cover property (erase_start_i && !busy_o && !prot);
	cover property (rejected_o);
endmodule
bind pfrc_top pfrc_top_sva u_sva (.*);
`default_nettype wire

/* File: pfrc_top_test.sv */
`default_nettype none
module pfrc_top_test;
	import pfrc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %0t %h %h", $time, g, e); end end
	logic            clk = 1'b0;
	logic            srst = 1'b1;
	logic            rd_go, cfg, pgm, er, wr, prot_code, rd_d, frd, busy, sup, rej, fer, fpg, p;
	logic [1:0]      wp;
	pfrc_reg_wr_type wr_s;
	logic [13:0]     rdata;
	logic [7:0]      ah, al, dh, dl;
	logic [14:0]     fad;
	logic [14:0]     pa[3] = '{15'h5000, 15'h2000, 15'h0A40};
	logic [31:0]     mask, got, exp_v, exp_q[$];
	logic [447:0]    wdat;
	int              ks[3] = '{0, 7, 31};
	int              err_count = 0, checks_done = 0, cyc = 0, seed = 34;
	always #50 clk = ~clk;
	pfrc_top u_dut (.clk_sys_i(clk), .srst_i(srst), .reg_wr_i(wr_s), .read_start_i(rd_go),
		.config_space_select_i(cfg), .program_space_select_i(pgm), .erase_start_i(er), .write_start_i(wr),
		.write_protect_field_i(wp), .code_protect_i(prot_code), .flash_rdata_i(rdata), .flash_addr_high_o(ah),
		.flash_addr_low_o(al), .flash_data_high_o(dh), .flash_data_low_o(dl), .busy_o(busy),
		.instr_suppress_o(sup), .rejected_o(rej), .flash_rd_o(frd), .flash_addr_o(fad), .flash_erase_o(fer),
		.flash_prog_o(fpg), .flash_prog_mask_o(mask), .flash_wdata_o(wdat));
	pfrc_flash_model u_mem (.rd_i(frd), .addr_i(fad), .rdata_o(rdata));
	// one byte write: sel 0 addr high, 1 addr low, 2 data high, 3 data low
	task automatic reg_w(input int sel, input logic [7:0] v);
		@(negedge clk);
		wr_s = {4'h8 >> sel, v};
		@(negedge clk);
		wr_s = '0;
	endtask
	task automatic pulse(ref logic s, input int n);
		@(negedge clk);
		s = 1'b1;
		repeat (n) @(negedge clk);
		s = 1'b0;
	endtask
	task automatic set_addr(input logic [14:0] a);
		reg_w(0, {1'b0, a[14:8]});
		reg_w(1, a[7:0]);
	endtask
	// read start held n cycles; the extra cycles land while busy and must be ignored
	task automatic do_read(input logic [14:0] a, input logic c, input int n);
		set_addr(a);
		cfg = c;
		pgm = !c;
		prot_code = 1'($random(seed));
		if (!c) exp_q.push_back({18'h0, a[13:0] ^ 14'h2A5B});
		pulse(rd_go, n);
		repeat (3) @(negedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// outputs are settled by the falling edge; any result takes the oldest note
	always @(negedge clk) begin
		got = rd_d ? {16'h0, dh, dl} : fpg ? mask : {30'h0, fer, rej};
		if (rd_d || fpg || fer || rej) begin
			exp_v = exp_q.pop_front();
			`CHK(got, exp_v)
		end
		rd_d = frd;
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			$display("MISMATCH %0t timeout", $time);
			tally_and_finish();
		end
	end
	initial begin
		{rd_go, cfg, pgm, er, wr, prot_code, wp, wr_s, rd_d} = '0;
		repeat (10) @(negedge clk);
		srst = 1'b0;
		// random words, a held start, a refused start
		repeat (6) do_read(15'($random(seed)), 1'b0, 1);
		do_read(15'h7FFF, 1'b0, 2);
		do_read(15'h0001, 1'b1, 1);
		// software reads one word of the row before it is rewritten
		do_read(15'h11E0, 1'b0, 1);
		$display("read test done");
		// partial row: three latches of one row in one batch
		wp = 2'h3;
		set_addr(15'h11E0);
		foreach (ks[i]) begin
			reg_w(1, 8'hE0 | 8'(ks[i]));
			reg_w(2, 8'h15);
			reg_w(3, 8'hC0 | 8'(ks[i]));
		end
		`CHK({dh, dl}, 16'h15DF)
		`CHK({ah, al}, 16'h11FF)
		`CHK(wdat[31*14 +: 14], 14'h15DF)
		exp_q.push_back(32'h8000_0081);
		pulse(wr, 1);
		// protected write drops its latches, so the next batch is empty
		reg_w(3, 8'h5A);
		wp = 2'h0;
		exp_q.push_back(32'h1);
		pulse(wr, 1);
		wp = 2'h3;
		exp_q.push_back(32'h0);
		pulse(wr, 1);
		$display("program test done");
		// every protection code against three segments
		foreach (pa[j]) for (int w = 0; w < 4; w++) begin
			set_addr(pa[j]);
			wp = 2'(w);
			p = w == 0 || (w == 1 && !pa[j][14]) || (w == 2 && pa[j][14:12] == 3'h0);
			exp_q.push_back(p ? 32'h1 : 32'h2);
			pulse(er, 1);
		end
		repeat (3) @(negedge clk);
		`CHK(exp_q.size(), 0)
		$display("erase test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
